/* File: design/ldm_matrix.sv */
// LED matrix display memories, address pointer and column scanner.
// How it works
// - Multilevel mode keeps a 28 by 8 dot memory of 6-bit values.
// - Multilevel dot address is column times 20h plus row.
// - A stored one lights its LED, a zero leaves it dark.
// - On/off mode: one byte per row, bit 7 is column 0.
// - A 28 by 8 fade memory holds 6-bit settings per dot.
// - Fade addresses use the same column-row layout as dot memory.
// - Fade write address advances by one and wraps after FBh.
// - Universal column memory holds eight bytes, one per time slot.
// - Slot byte drives the columns, bit 7 is column 0.
// - A one switches its column on, a zero keeps it off.
// - Universal column write address increments and wraps after 07h.
// - Row and column on-times follow a global duty in sixty-fourths.
// - The scanner covers 224 dots: 28 rows over 8 columns.
// - A pointer load starts a write, following bytes load onward.
`timescale 1ns/100ps
`default_nettype none
module ldm_matrix #(
    parameter int STEP_CYCLES = ldm_pkg::STEP_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ptr_load,
    input wire logic [7:0] ptr_addr,
    input wire logic [1:0] mem_sel,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    input wire logic gray_mode,
    input wire logic universal_column_pattern_mode,
    input wire logic display_on,
    input wire logic [6:0] duty,
    output logic [27:0] row_drive_q,
    output logic [7:0] column_drive_line_q,
    output logic [2:0] scan_time_slot_q,
    output logic [7:0] ptr_q,
    output logic [5:0] fade_setting,
    output logic [4:0] fade_row_q,
    output logic fade_valid_q
);
    localparam int ROWS = ldm_pkg::ROWS;
    localparam int SCW = $clog2(STEP_CYCLES + 1);

    if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_chk
        $error("STEP_CYCLES out of range.");
    end

    // ==========================================================
    // Address helpers
    function automatic logic [7:0] last_addr(input logic [1:0] sel);
        unique case (sel)
            ldm_pkg::LDM_MEM_BIN: last_addr = ldm_pkg::BIN_LAST;
            ldm_pkg::LDM_MEM_GRAY: last_addr = ldm_pkg::GRAY_LAST;
            ldm_pkg::LDM_MEM_FADE: last_addr = ldm_pkg::FADE_LAST;
            ldm_pkg::LDM_MEM_UNIVERSAL_COLUMN_PATTERN: last_addr = ldm_pkg::UNIVERSAL_COLUMN_PATTERN_LAST;
        endcase
    endfunction : last_addr

    function automatic logic row_ok(input logic [7:0] a);
        row_ok = a[ldm_pkg::ROW_LSB +: ldm_pkg::ROW_BITS] < 5'(ROWS);
    endfunction : row_ok

    // ==========================================================
    // Address pointer
    logic [7:0] ptr_d;
    logic wr_go;
    logic wr_bin;
    logic wr_gray;
    logic wr_fade;
    logic wr_universal_column_pattern;
    logic dot_ok;

    assign wr_go = data_valid && !ptr_load;
    assign dot_ok = row_ok(ptr_q);
    assign ptr_d = ptr_load ? ptr_addr
        : !wr_go ? ptr_q
        : (ptr_q >= last_addr(mem_sel)) ? ldm_pkg::ADDR_RESET
        : ptr_q + 8'h01;
    assign wr_bin = wr_go && mem_sel == ldm_pkg::LDM_MEM_BIN
        && ptr_q <= ldm_pkg::BIN_LAST;
    assign wr_gray = wr_go && mem_sel == ldm_pkg::LDM_MEM_GRAY && dot_ok
        && ptr_q <= ldm_pkg::GRAY_LAST;
    assign wr_fade = wr_go && mem_sel == ldm_pkg::LDM_MEM_FADE && dot_ok
        && ptr_q <= ldm_pkg::FADE_LAST;
    assign wr_universal_column_pattern = wr_go && mem_sel == ldm_pkg::LDM_MEM_UNIVERSAL_COLUMN_PATTERN
        && ptr_q <= ldm_pkg::UNIVERSAL_COLUMN_PATTERN_LAST;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ptr_q <= ldm_pkg::ADDR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // ==========================================================
    // On/off and universal column memories
    logic [7:0] bin_q [ROWS];
    logic [7:0] universal_column_pattern_q [ldm_pkg::COLS];

    always_ff @(posedge ref_clk) begin
        if (wr_bin) begin
            bin_q[ptr_q[4:0]] <= data_byte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_universal_column_pattern) begin
            universal_column_pattern_q[ptr_q[2:0]] <= data_byte;
        end
    end

    // ==========================================================
    // Multilevel and fade memories
    logic [7:0] rd_addr;
    logic [5:0] gray_rd;

    ldm_dot_ram #(
        .WIDTH(ldm_pkg::DOT_W),
        .DEPTH(ldm_pkg::RAM_DEPTH),
        .AW(8)
    ) u_gray (
        .ref_clk(ref_clk),
        .wr_en(wr_gray),
        .wr_addr(ptr_q),
        .wr_data(data_byte[5:0]),
        .rd_addr(rd_addr),
        .rd_data_q(gray_rd)
    );

    ldm_dot_ram #(
        .WIDTH(ldm_pkg::DOT_W),
        .DEPTH(ldm_pkg::RAM_DEPTH),
        .AW(8)
    ) u_fade (
        .ref_clk(ref_clk),
        .wr_en(wr_fade),
        .wr_addr(ptr_q),
        .wr_data(data_byte[5:0]),
        .rd_addr(rd_addr),
        .rd_data_q(fade_setting)
    );

    // ==========================================================
    // Scan sequencer
    ldm_pkg::ldm_scan_state_t st_q;
    ldm_pkg::ldm_scan_state_t st_d;
    logic [5:0] ld_cnt_q;
    logic [5:0] ld_cnt_d;
    logic [SCW-1:0] step_q;
    logic [SCW-1:0] step_d;
    logic [5:0] pwm_q;
    logic [5:0] pwm_d;
    logic [2:0] slot_d;
    logic step_end;
    logic load_end;
    logic cap_q;
    logic [4:0] cap_row_q;
    logic [5:0] lat_q [ROWS];

    assign load_end = ld_cnt_q == 6'(ldm_pkg::LOAD_CYCLES - 1);
    assign step_end = step_q == SCW'(STEP_CYCLES - 1);
    assign rd_addr = {scan_time_slot_q, ld_cnt_q[4:0]};

    always_comb begin
        st_d = st_q;
        ld_cnt_d = ld_cnt_q;
        step_d = step_q;
        pwm_d = pwm_q;
        slot_d = scan_time_slot_q;
        unique case (st_q)
            ldm_pkg::LDM_SCAN_LOAD: begin
                ld_cnt_d = ld_cnt_q + 6'd1;
                if (load_end) begin
                    st_d = ldm_pkg::LDM_SCAN_PWM;
                    ld_cnt_d = 6'd0;
                end
            end
            ldm_pkg::LDM_SCAN_PWM: begin
                step_d = step_end ? '0 : step_q + SCW'(1);
                if (step_end) begin
                    pwm_d = pwm_q + 6'd1;
                    if (pwm_q == 6'(ldm_pkg::PWM_STEPS - 1)) begin
                        st_d = ldm_pkg::LDM_SCAN_LOAD;
                        slot_d = scan_time_slot_q + 3'd1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= ldm_pkg::LDM_SCAN_LOAD;
            ld_cnt_q <= 6'd0;
            step_q <= '0;
            pwm_q <= 6'd0;
            scan_time_slot_q <= 3'd0;
        end else begin
            st_q <= st_d;
            ld_cnt_q <= ld_cnt_d;
            step_q <= step_d;
            pwm_q <= pwm_d;
            scan_time_slot_q <= slot_d;
        end
    end

    // ==========================================================
    // Row value capture during the load phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cap_q <= 1'b0;
            cap_row_q <= 5'd0;
        end else begin
            cap_q <= st_q == ldm_pkg::LDM_SCAN_LOAD
                && ld_cnt_q < 6'(ROWS);
            cap_row_q <= ld_cnt_q[4:0];
        end
    end

    assign fade_row_q = cap_row_q;
    assign fade_valid_q = cap_q;

    always_ff @(posedge ref_clk) begin
        if (cap_q) begin
            lat_q[cap_row_q] <= gray_rd;
        end
    end

    // ==========================================================
    // Output drive
    logic duty_on;
    logic lit_phase;
    logic [27:0] row_d;
    logic [7:0] col_d;
    logic [2:0] col_bit;

    assign duty_on = {1'b0, pwm_q} < duty;
    assign lit_phase = display_on && st_q == ldm_pkg::LDM_SCAN_PWM && duty_on;
    assign col_bit = 3'd7 - scan_time_slot_q;

    for (genvar r = 0; r < ROWS; r++) begin : g_row
        logic [11:0] want;
        logic [11:0] have;
        assign want = {pwm_q, 6'd0};
        assign have = 12'(lat_q[r]) * 12'(duty);
        assign row_d[r] = lit_phase && (gray_mode ? want < have
            : bin_q[r][col_bit]);
    end

    for (genvar c = 0; c < ldm_pkg::COLS; c++) begin : g_col
        assign col_d[c] = lit_phase && (universal_column_pattern_mode
            ? universal_column_pattern_q[scan_time_slot_q][7 - c]
            : scan_time_slot_q == 3'(c));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            row_drive_q <= 28'h0000000;
            column_drive_line_q <= 8'h00;
        end else begin
            row_drive_q <= row_d;
            column_drive_line_q <= col_d;
        end
    end
endmodule : ldm_matrix
`default_nettype wire

/* File: design/ldm_pkg.sv */
// Shared constants and types for the LED matrix display memory and scanner.
package ldm_pkg;
    // ==========================================================
    // Matrix geometry
    localparam int ROWS = 28;
    localparam int COLS = 8;
    localparam int DOT_W = 6;
    localparam int PWM_STEPS = 64;
    localparam int RAM_DEPTH = 256;

    // ==========================================================
    // Address layout and wrap points
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] GRAY_LAST = 8'hfb;
    localparam logic [7:0] FADE_LAST = 8'hfb;
    localparam logic [7:0] BIN_LAST = 8'h1b;
    localparam logic [7:0] UNIVERSAL_COLUMN_PATTERN_LAST = 8'h07;
    localparam int ROW_LSB = 0;
    localparam int ROW_BITS = 5;
    localparam int COL_LSB = 5;
    localparam int COL_BITS = 3;

    // ==========================================================
    // Timing
    localparam int LOAD_CYCLES = ROWS + 1;
    localparam int STEP_CYCLES_DEF = 16;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LDM_MEM_BIN = 2'b00,
        LDM_MEM_GRAY = 2'b01,
        LDM_MEM_FADE = 2'b10,
        LDM_MEM_UNIVERSAL_COLUMN_PATTERN = 2'b11
    } ldm_mem_sel_t;

    typedef enum logic [0:0] {
        LDM_SCAN_LOAD = 1'b0,
        LDM_SCAN_PWM = 1'b1
    } ldm_scan_state_t;
endpackage : ldm_pkg

/* File: design/ldm_dot_ram.sv */
// Small dual-port dot memory with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module ldm_dot_ram #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("Depth does not fit the address width.");
    end

    // ==========================================================
    // Write and registered read
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule : ldm_dot_ram
`default_nettype wire

/* File: verification/ldm_matrix_checker.sv */
// Port checks for the display memory block.
`timescale 1ns/100ps
`default_nettype none
module ldm_matrix_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ptr_load,
    input wire logic [7:0] ptr_addr,
    input wire logic [1:0] mem_sel,
    input wire logic data_valid,
    input wire logic universal_column_pattern_mode,
    input wire logic [7:0] column_drive_line_q,
    input wire logic [2:0] scan_time_slot_q,
    input wire logic [7:0] ptr_q,
    input wire logic [4:0] fade_row_q,
    input wire logic fade_valid_q
);
    // ==========================================================
    // Pointer and scan checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic wf;
    logic wu;
    assign wf = data_valid && !ptr_load && mem_sel == 2'd2;
    assign wu = data_valid && !ptr_load && mem_sel == 2'd3;
    AST_PTR_LOAD: assert property (ptr_load |=> ptr_q == $past(ptr_addr))
        else $error("pointer not loaded");
    AST_FADE_INC: assert property (wf && ptr_q < 8'hfb |=>
        ptr_q == $past(ptr_q) + 8'h01) else $error("fade pointer step");
    AST_FADE_WRAP: assert property (wf && ptr_q == 8'hfb |=> ptr_q == 8'h00)
        else $error("fade pointer wrap");
    AST_UNIVERSAL_COLUMN_PATTERN_INC: assert property (wu && ptr_q < 8'h07 |=>
        ptr_q == $past(ptr_q) + 8'h01) else $error("universal_column_pattern pointer step");
    AST_UNIVERSAL_COLUMN_PATTERN_WRAP: assert property (wu && ptr_q == 8'h07 ##1 1'b1 |->
        ptr_q == 8'h00) else $error("universal_column_pattern pointer wrap");
    AST_ONEHOT: assert property (!universal_column_pattern_mode && !$past(universal_column_pattern_mode) &&
        column_drive_line_q != 8'h00 |->
        column_drive_line_q == 8'h01 << $past(scan_time_slot_q))
        else $error("column not one-hot");
    AST_SLOT_STEP: assert property ($changed(scan_time_slot_q) |->
        scan_time_slot_q == $past(scan_time_slot_q) + 3'd1)
        else $error("slot order");
    AST_FADE_ROW: assert property (fade_valid_q |-> fade_row_q < 5'd28 &&
        column_drive_line_q == 8'h00) else $error("fade row range");
    cover property (wf && ptr_q == 8'hfb);
    cover property (universal_column_pattern_mode && column_drive_line_q != 8'h00);
    cover property (fade_valid_q && fade_row_q == 5'd27);
endmodule : ldm_matrix_checker
bind ldm_matrix ldm_matrix_checker chk (.ref_clk, .rst, .ptr_load, .ptr_addr,
    .mem_sel, .data_valid, .universal_column_pattern_mode, .column_drive_line_q,
    .scan_time_slot_q, .ptr_q, .fade_row_q, .fade_valid_q);
`default_nettype wire

/* File: verification/ldm_host.sv */
// Host model that loads the pointer and writes memory bytes.
`timescale 1ns/100ps
`default_nettype none
module ldm_host (
    input wire logic ref_clk,
    output logic ptr_load = 1'b0,
    output logic [7:0] ptr_addr = 8'h00,
    output logic [1:0] mem_sel = 2'd0,
    output logic data_valid = 1'b0,
    output logic [7:0] data_byte = 8'h00
);
    // ==========================================================
    // Memory image and pointer notes
    logic [7:0] img [4][256];
    logic [7:0] q [$];
    int seed = 32'h4685a037;
    task automatic wr(input logic [1:0] s, input logic [7:0] a, input int n,
                      input bit r);
        logic [7:0] p;
        logic [7:0] d;
        logic [7:0] last;
        p = a;
        last = s == 2'd0 ? 8'h1b : s == 2'd3 ? 8'h07 : 8'hfb;
        @(posedge ref_clk);
        mem_sel <= s;
        ptr_load <= 1'b1;
        ptr_addr <= a;
        q.push_back(a);
        for (int i = 0; i < n; i++) begin
            d = r ? 8'($random(seed)) : 8'h00;
            @(posedge ref_clk);
            ptr_load <= 1'b0;
            ptr_addr <= ~a;
            data_valid <= 1'b1;
            data_byte <= d;
            if (p <= last && (s[0] == s[1] || p[4:0] < 5'd28))
                img[s][p] = s[0] ^ s[1] ? {2'b00, d[5:0]} : d;
            p = p >= last ? 8'h00 : p + 8'h01;
            q.push_back(p);
        end
        @(posedge ref_clk);
        data_valid <= 1'b0;
        data_byte <= ~d;
    endtask : wr
endmodule : ldm_host
`default_nettype wire

/* File: verification/tb_ldm_matrix.sv */
// Self-checking bench for the display memory and scanner.
`timescale 1ns/100ps
`default_nettype none
module tb_ldm_matrix;
    // ==========================================================
    // Clock, wiring and checks
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic gray_mode = 1'b0, universal_column_pattern_mode = 1'b0, display_on = 1'b1, tk = 1'b0;
    logic [6:0] duty = 7'd64;
    logic [27:0] rx;
    logic [7:0] cx;
    logic [2:0] ps = 3'd0;
    wire logic ptr_load, data_valid, fade_valid_q;
    wire logic [7:0] ptr_addr, data_byte, column_drive_line_q, ptr_q;
    wire logic [1:0] mem_sel;
    wire logic [27:0] row_drive_q;
    wire logic [2:0] scan_time_slot_q;
    wire logic [5:0] fade_setting;
    wire logic [4:0] fade_row_q;
    int failures = 0, n_compared = 0, md = 0, lit = 0, ex = 0, v;
    always #2 ref_clk = ~ref_clk;
    ldm_host h (.ref_clk(ref_clk), .ptr_load(ptr_load), .ptr_addr(ptr_addr),
        .mem_sel(mem_sel), .data_valid(data_valid), .data_byte(data_byte));
    ldm_matrix #(.STEP_CYCLES(1)) dut (.ref_clk(ref_clk), .rst(rst),
        .ptr_load(ptr_load), .ptr_addr(ptr_addr), .mem_sel(mem_sel),
        .data_valid(data_valid), .data_byte(data_byte),
        .gray_mode(gray_mode), .universal_column_pattern_mode(universal_column_pattern_mode),
        .display_on(display_on), .duty(duty), .row_drive_q(row_drive_q),
        .column_drive_line_q(column_drive_line_q),
        .scan_time_slot_q(scan_time_slot_q), .ptr_q(ptr_q),
        .fade_setting(fade_setting), .fade_row_q(fade_row_q),
        .fade_valid_q(fade_valid_q));
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    always @(posedge ref_clk) begin
        if (tk) chk("ptr_q", ptr_q, h.q.pop_front());
        tk <= ptr_load | data_valid;
        // Outputs lag the slot by one cycle, so use the slot they were made in.
        ps <= scan_time_slot_q;
        for (int r = 0; r < 28; r++) rx[r] = h.img[0][r][7 - ps];
        for (int c = 0; c < 8; c++) cx[c] = h.img[3][ps][7 - c];
        if (md == 1 && column_drive_line_q != 8'h00)
            chk("rows", row_drive_q, rx);
        if (md == 2 && column_drive_line_q != 8'h00)
            chk("cols", column_drive_line_q, cx);
        if (md != 0 && fade_valid_q) chk("fade", fade_setting, h.img[2][{scan_time_slot_q, fade_row_q}]);
    end
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        chk("reset", {ptr_q, scan_time_slot_q, column_drive_line_q}, 0);
        h.wr(2'd0, 8'h00, 28, 0);
        h.wr(2'd1, 8'h00, 252, 0);
        h.wr(2'd2, 8'h00, 252, 0);
        h.wr(2'd3, 8'h00, 8, 0);
        h.wr(2'd0, 8'h1a, 30, 1);
        h.wr(2'd3, 8'h06, 10, 1);
        h.wr(2'd2, 8'hfa, 254, 1);
        md = 1;
        repeat (1488) @(posedge ref_clk);
        md = 0;
        universal_column_pattern_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        md = 2;
        repeat (1488) @(posedge ref_clk);
        md = 0;
        universal_column_pattern_mode <= 1'b0;
        gray_mode <= 1'b1;
        duty <= 7'd17;
        h.wr(2'd1, 8'h65, 1, 1);
        v = h.img[1][8'h65][5:0];
        for (int p = 0; p < 64; p++) ex += (p < 17 && p * 64 < v * 17);
        display_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        display_on <= 1'b1;
        repeat (744) @(posedge ref_clk);
        repeat (744) begin
            @(posedge ref_clk);
            lit += (row_drive_q[5] === 1'b1);
        end
        chk("on_time", lit, ex);
        test_done();
    end
endmodule : tb_ldm_matrix
`default_nettype wire
